// File: rtl/sms_pkg.sv
// Purpose: Shared constants and types of the serial master/slave port
// Assumes: Word-wide register bus, byte addresses, 50 MHz core clock
// Notes:   Every user of this package writes sms_pkg::name
//
// Functional notes
// - Setup bit 15 selects slave at 0, master at 1; resets to 0.
// - Per-device phase bits 14:10; 1 toggles clock from transfer start.
// - Per-device enable polarity bits 9:5; 0 active low, 1 active high.
// - Per-device clock idle bits 4:0; 0 rests low, 1 rests high.
// - Slave ends a transaction when the select leaves its active level.
// - Setup or control writes during a transaction are dropped with error.
// - New idle and polarity settings act two clock cycles after the write.
// - Control bits 9:7 pick which device enable is driven.
// - Control bits 6:2 give transfer length minus one.
// - Control bit 1 starts transmit only, bit 0 receive and transmit.
// - Status bit 1, transmit empty, resets 1, cleared by a transmit write to the top byte lane.
// - Status bit 0, receive full, resets 0, cleared by functional read only.
// - Transmit word right aligned, highest used bit shifted out first.
// - Transmit full once the byte lane holding the top bits is written.
// - Receive empty once the top byte lane is read functionally; the code stays full while more words wait in the FIFO.
// - Test bits: force output, forced value, input, clock, enables.
// - Test bit 0 loops output to input; register reads zero when off.
// - Activation bits clear one shift clock cycle after the start.
// - Finished receive copies shift register to receive side, flags read end.
package sms_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SETUP_TWO = 8'h28;
	localparam logic [7:0] OFS_CONTROL   = 8'h2C;
	localparam logic [7:0] OFS_STATUS    = 8'h30;
	localparam logic [7:0] OFS_TX        = 8'h34;
	localparam logic [7:0] OFS_RX        = 8'h38;
	localparam logic [7:0] OFS_TEST      = 8'h3C;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int NDEV        = 5;
	localparam int SET2_W      = 16;
	localparam int SET2_ROLE   = 15;
	localparam int SET2_CP_LO  = 10;
	localparam int SET2_CE_LO  = 5;
	localparam int SET2_CI_LO  = 0;
	localparam int CTRL_W      = 10;
	localparam int CTRL_TGT_LO = 7;
	localparam int CTRL_CNT_LO = 2;
	localparam int CTRL_LANE   = 5;
	localparam int CTRL_WR     = 1;
	localparam int CTRL_RD     = 0;
	localparam int TEST_W      = 5;
	localparam int TEST_MODE   = 0;
	localparam int TEST_FDO    = 1;
	localparam int TEST_WTV    = 2;
	localparam int TEST_WCV    = 4;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [SET2_W-1:0] SET2_RST  = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_RST  = 10'h000;
	localparam logic [TEST_W-1:0] TEST_RST  = 5'h00;
	localparam logic [TEST_W-1:0] TEST_WMSK = 5'h17;
	localparam logic [31:0]       TX_RST    = 32'h0000_0000;
	localparam logic              TXE_RST   = 1'b1;

	// ----------------------------------------------------------------
	// Bus codes
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_WR    = 3'h1;
	localparam logic [2:0] CMD_RD    = 3'h2;
	localparam logic [1:0] RESP_NULL = 2'h0;
	localparam logic [1:0] RESP_DVA  = 2'h1;
	localparam logic [1:0] RESP_ERR  = 2'h3;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS       = 20;
	localparam int SCK_HALF_NS  = 80;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int FIFO_DEPTH   = 4;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} sms_state_type;

	// Byte-lane merge of a bus write
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = new_v[8*i +: 8];
		return r;
	endfunction

endpackage

// File: rtl/sms_stream_if.sv
// Purpose: Valid/ready word stream between the port and its buffer
// Assumes: Single clock domain
// Notes:   src drives data, snk answers ready
`timescale 1ns/1ps
interface sms_stream_if #(parameter int W = 32);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// File: rtl/sms_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are slow levels relative to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sms_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// Two stages against metastability
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// File: rtl/sms_fifo.sv
// Purpose: Small flip-flop FIFO on the receive path
// Assumes: Same clock on both sides
// Notes:   Full drops in_s.ready so the source stalls
`timescale 1ns/1ps
module sms_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Streams
	sms_stream_if.snk in_s,
	sms_stream_if.src out_s
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2)
	begin : g_bad_depth
		$error("sms_fifo: DEPTH must be at least 2");
	end

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [CW-1:0] cnt_q;
	logic          push;
	logic          pop;

	assign in_s.ready  = (cnt_q != CW'(DEPTH));
	assign out_s.valid = (cnt_q != '0);
	assign out_s.data  = mem_q[rp_q];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	// Storage
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wp_q] <= in_s.data;
	end

	// Pointers and fill level
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end
endmodule

// File: rtl/sms_port.sv
// Purpose: Four-line serial port, master or slave, with register bus slave
// Assumes: Link pins asynchronous to clk; shift clock sampled in slave mode
// Notes:   Received words queue in a small FIFO in front of the read register
`timescale 1ns/1ps
module sms_port #(
	parameter int HALF_CYC = sms_pkg::SCK_HALF_CYC,
	parameter int RX_DEPTH = sms_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Register bus
	input  wire logic [2:0]  ocp_mcmd,
	input  wire logic [7:0]  ocp_maddr,
	input  wire logic [31:0] ocp_mdata,
	input  wire logic [3:0]  ocp_mbyteen,
	input  wire logic        ocp_dbg_access,
	output logic             ocp_scmdaccept,
	output logic [1:0]       ocp_sresp,
	output logic [31:0]      ocp_sdata,
	// Shift clock pin
	input  wire logic        shift_clock_i,
	output logic             shift_clock_o,
	output logic             shift_clock_oe,
	// Data pins
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	// Device enables, bit 0 doubles as slave select input
	input  wire logic        slave_select_in,
	output logic [4:0]       dev_enable_o,
	output logic             dev_enable0_oe,
	// Status
	output logic             read_end
);
	if (HALF_CYC < 1 || RX_DEPTH < 2)
	begin : g_bad_param
		$error("sms_port: HALF_CYC >= 1 and RX_DEPTH >= 2 required");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int DW = $clog2(HALF_CYC + 1);

	sms_pkg::sms_state_type state_q;
	logic [sms_pkg::SET2_W-1:0] set2_q;
	logic [sms_pkg::CTRL_W-1:0] ctrl_q;
	logic [sms_pkg::TEST_W-1:0] test_q;
	logic [31:0] tx_q;
	logic [31:0] shift_q;
	logic [9:0]  cfg_p1_q;
	logic [9:0]  cfg_q;
	logic [DW-1:0] div_q;
	logic [6:0]  ecnt_q;
	logic        tog_q;
	logic        dout_q;
	logic        txe_q;
	logic        kind_rd_q;
	logic        sck_p_q;
	logic        sel_p_q;
	logic [2:0]  pins_s;
	logic        sck_s;
	logic        din_s;
	logic        sel_s;

	logic        role;
	logic        tm;
	logic [2:0]  tgt;
	logic [4:0]  nb;
	logic [1:0]  lane;
	logic [6:0]  edges;
	logic        cp_u;
	logic        ci_u;
	logic        ce_u;
	logic        din_eff;
	logic        sel_act;
	logic        bus_wr;
	logic        bus_rd;
	logic        hit;
	logic        busy;
	logic        locked;
	logic        act;
	logic        start;
	logic        tick;
	logic        ev;
	logic        cap;
	logic        fin;
	logic        act_clr;
	logic        lead;
	logic        trail;
	logic [31:0] rdata;

	sms_stream_if #(.W(32)) push_s ();
	sms_stream_if #(.W(32)) pop_s ();

	// ----------------------------------------------------------------
	// Pin synchronisers and receive buffer
	// ----------------------------------------------------------------
	sms_sync #(.W(3)) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({shift_clock_i, serial_in_pin, slave_select_in}),
		.q    (pins_s)
	);
	assign sck_s = pins_s[2];
	assign din_s = pins_s[1];
	assign sel_s = pins_s[0];

	sms_fifo #(.W(32), .DEPTH(RX_DEPTH)) u_rx_fifo (
		.clk   (clk),
		.srst  (srst),
		.in_s  (push_s),
		.out_s (pop_s)
	);

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	assign role  = set2_q[sms_pkg::SET2_ROLE];
	assign tm    = test_q[sms_pkg::TEST_MODE];
	assign tgt   = (ctrl_q[sms_pkg::CTRL_TGT_LO +: 3] < 3'(sms_pkg::NDEV))
		? ctrl_q[sms_pkg::CTRL_TGT_LO +: 3] : 3'h0;
	assign nb    = ctrl_q[sms_pkg::CTRL_CNT_LO +: 5];
	assign lane  = ctrl_q[sms_pkg::CTRL_LANE +: 2];
	assign edges = {1'b0, nb, 1'b0} + 7'h02;
	// Slave follows device 0 settings only
	assign cp_u  = set2_q[sms_pkg::SET2_CP_LO + (role ? tgt : 3'h0)];
	assign ci_u  = cfg_q[role ? tgt : 3'h0];
	assign ce_u  = cfg_q[sms_pkg::SET2_CE_LO + (role ? tgt : 3'h0)];
	assign din_eff = tm ? serial_out_pin : din_s;
	assign sel_act = (sel_s == ce_u);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign bus_wr = (ocp_mcmd == sms_pkg::CMD_WR);
	assign bus_rd = (ocp_mcmd == sms_pkg::CMD_RD);
	assign hit = (ocp_maddr == sms_pkg::OFS_SETUP_TWO) || (ocp_maddr == sms_pkg::OFS_CONTROL)
		|| (ocp_maddr == sms_pkg::OFS_STATUS) || (ocp_maddr == sms_pkg::OFS_TX)
		|| (ocp_maddr == sms_pkg::OFS_RX) || (ocp_maddr == sms_pkg::OFS_TEST);
	assign busy   = (state_q == sms_pkg::ST_RUN);
	assign locked = busy && bus_wr && ((ocp_maddr == sms_pkg::OFS_SETUP_TWO)
		|| (ocp_maddr == sms_pkg::OFS_CONTROL));

	// ----------------------------------------------------------------
	// Sequencing terms
	// ----------------------------------------------------------------
	// A receive only starts with room in the buffer, so no word is lost
	assign act   = ctrl_q[sms_pkg::CTRL_WR] || ctrl_q[sms_pkg::CTRL_RD];
	assign start = (state_q == sms_pkg::ST_IDLE) && act
		&& (!ctrl_q[sms_pkg::CTRL_RD] || push_s.ready);
	assign tick  = busy && role && (div_q == DW'(HALF_CYC - 1));
	assign lead  = (sck_s != ci_u) && (sck_p_q == ci_u);
	assign trail = (sck_s == ci_u) && (sck_p_q != ci_u);
	assign ev    = role ? (tick && (ecnt_q < edges)) : (busy && (lead || trail));
	// Phase 0 samples on leading edges, phase 1 on trailing edges
	assign cap   = role ? (ev && (ecnt_q[0] == cp_u)) : (ev && (cp_u ? trail : lead));
	assign fin   = role ? (tick && (ecnt_q == edges))
		: (busy && sel_p_q && !sel_act);
	assign act_clr = (ev && (ecnt_q == 7'h01)) || fin;

	// ----------------------------------------------------------------
	// Transfer state and shift clock timing
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= sms_pkg::ST_IDLE;
			div_q   <= '0;
			ecnt_q  <= '0;
			tog_q   <= 1'b0;
		end
		else
		begin
			case (state_q)
				sms_pkg::ST_IDLE:
				begin
					div_q  <= '0;
					ecnt_q <= '0;
					tog_q  <= 1'b0;
					if (start)
						state_q <= role ? sms_pkg::ST_RUN : sms_pkg::ST_WAIT;
				end
				sms_pkg::ST_WAIT:
				begin
					if (sel_act)
						state_q <= sms_pkg::ST_RUN;
				end
				sms_pkg::ST_RUN:
				begin
					div_q <= tick ? '0 : div_q + 1'b1;
					if (ev)
					begin
						ecnt_q <= ecnt_q + 7'h01;
						tog_q  <= ~tog_q;
					end
					if (fin)
						state_q <= sms_pkg::ST_IDLE;
				end
				default:
					state_q <= sms_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Shift register and serial data
	// ----------------------------------------------------------------
	// Output bit moves on shift edges, input enters on capture edges
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			shift_q   <= '0;
			dout_q    <= 1'b0;
			kind_rd_q <= 1'b0;
		end
		else if (start)
		begin
			shift_q   <= tx_q;
			dout_q    <= tx_q[nb];
			kind_rd_q <= ctrl_q[sms_pkg::CTRL_RD];
		end
		else if (cap)
			shift_q <= {shift_q[30:0], din_eff};
		else if (ev)
			dout_q <= shift_q[nb];
	end

	// Finished receive lands in the buffer
	assign push_s.valid = fin && kind_rd_q;
	assign push_s.data  = shift_q;
	assign pop_s.ready  = bus_rd && (ocp_maddr == sms_pkg::OFS_RX)
		&& !ocp_dbg_access && ocp_mbyteen[lane];

	// ----------------------------------------------------------------
	// Setup, control and test registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			set2_q <= sms_pkg::SET2_RST;
			ctrl_q <= sms_pkg::CTRL_RST;
			test_q <= sms_pkg::TEST_RST;
		end
		else
		begin
			if (bus_wr && !locked && (ocp_maddr == sms_pkg::OFS_SETUP_TWO))
				set2_q <= sms_pkg::SET2_W'(sms_pkg::merge(32'(set2_q), ocp_mdata,
					ocp_mbyteen));
			if (bus_wr && !locked && (ocp_maddr == sms_pkg::OFS_CONTROL))
				ctrl_q <= sms_pkg::CTRL_W'(sms_pkg::merge(32'(ctrl_q), ocp_mdata,
					ocp_mbyteen));
			else if (act_clr)
				ctrl_q[1:0] <= 2'h0;
			if (bus_wr && (ocp_maddr == sms_pkg::OFS_TEST))
				test_q <= sms_pkg::TEST_W'(sms_pkg::merge(32'(test_q), ocp_mdata,
					ocp_mbyteen)) & sms_pkg::TEST_WMSK;
		end
	end

	// Idle and polarity settings reach the pins two cycles late
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cfg_p1_q <= sms_pkg::SET2_RST[9:0];
			cfg_q    <= sms_pkg::SET2_RST[9:0];
		end
		else
		begin
			cfg_p1_q <= set2_q[9:0];
			cfg_q    <= cfg_p1_q;
		end
	end

	// ----------------------------------------------------------------
	// Transmit register and data status
	// ----------------------------------------------------------------
	// Completion sets empty and wins over a same-cycle write
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tx_q  <= sms_pkg::TX_RST;
			txe_q <= sms_pkg::TXE_RST;
		end
		else
		begin
			if (bus_wr && (ocp_maddr == sms_pkg::OFS_TX))
				tx_q <= sms_pkg::merge(tx_q, ocp_mdata, ocp_mbyteen);
			if (fin)
				txe_q <= 1'b1;
			else if (bus_wr && (ocp_maddr == sms_pkg::OFS_TX) && ocp_mbyteen[lane])
				txe_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata = '0;
		case (ocp_maddr)
			sms_pkg::OFS_SETUP_TWO: rdata = 32'(set2_q);
			sms_pkg::OFS_CONTROL:   rdata = 32'(ctrl_q);
			sms_pkg::OFS_STATUS:    rdata = {30'h0, txe_q, pop_s.valid};
			sms_pkg::OFS_TX:        rdata = tx_q;
			sms_pkg::OFS_RX:        rdata = pop_s.valid ? pop_s.data : '0;
			sms_pkg::OFS_TEST:      rdata = tm ? {21'h0, dev_enable_o, sck_s,
				test_q[4], din_eff, test_q[2:0]} : '0;
			default:                rdata = '0;
		endcase
	end

	// Every read or write command gets one answer the cycle after
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ocp_scmdaccept <= 1'b0;
			ocp_sresp      <= sms_pkg::RESP_NULL;
			ocp_sdata      <= '0;
		end
		else
		begin
			ocp_scmdaccept <= 1'b1;
			ocp_sresp      <= sms_pkg::RESP_NULL;
			ocp_sdata      <= '0;
			if (bus_wr || bus_rd)
				ocp_sresp <= (hit && !locked) ? sms_pkg::RESP_DVA : sms_pkg::RESP_ERR;
			if (bus_rd)
				ocp_sdata <= rdata;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Enable of the chosen device is active only in a master transfer
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			dev_enable_o   <= 5'h1F;
			dev_enable0_oe <= 1'b0;
			shift_clock_o  <= 1'b0;
			shift_clock_oe <= 1'b0;
			serial_out_pin <= 1'b0;
			sck_p_q        <= 1'b0;
			sel_p_q        <= 1'b0;
			read_end       <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < sms_pkg::NDEV; i++)
				dev_enable_o[i] <= (busy && role && (tgt == 3'(i)))
					? cfg_q[5+i] : ~cfg_q[5+i];
			dev_enable0_oe <= role;
			shift_clock_oe <= role;
			shift_clock_o  <= tm ? test_q[sms_pkg::TEST_WCV] : (ci_u ^ tog_q);
			serial_out_pin <= (tm && test_q[sms_pkg::TEST_FDO])
				? test_q[sms_pkg::TEST_WTV] : dout_q;
			sck_p_q <= sck_s;
			sel_p_q <= busy && sel_act;
			if (fin && kind_rd_q)
				read_end <= 1'b1;
			else if (start)
				read_end <= 1'b0;
		end
	end

endmodule

// File: verif/sms_port_props.sv
// Purpose: Bus answer and pin enable checks on the serial port top ports
// Assumes: One clock domain, sync reset
// Notes:   Bound into every sms_port instance
`timescale 1ns/1ps
module sms_port_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        srst,
	// Bus
	input wire logic [2:0]  ocp_mcmd,
	input wire logic [7:0]  ocp_maddr,
	input wire logic        ocp_scmdaccept,
	input wire logic [1:0]  ocp_sresp,
	input wire logic [31:0] ocp_sdata,
	// Pins
	input wire logic        shift_clock_oe,
	input wire logic        dev_enable0_oe,
	input wire logic        read_end
);
	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Address decode, full byte compare
	wire mapped = ocp_maddr inside {8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
	wire rd     = ocp_mcmd == sms_pkg::CMD_RD;
	answer_due_a: assert property (ocp_mcmd != 3'h0 |=> ocp_sresp != sms_pkg::RESP_NULL)
		else $error("no answer to command");
	no_stray_a: assert property (ocp_mcmd == 3'h0 |=> ocp_sresp == sms_pkg::RESP_NULL)
		else $error("answer without command");
	accept_on_a: assert property (!$past(srst) |-> ocp_scmdaccept)
		else $error("command accept low");
	unmapped_err_a: assert property (ocp_mcmd != 3'h0 && !mapped |=> ocp_sresp == 2'h3)
		else $error("unmapped access not refused");
	role_pins_a: assert property (shift_clock_oe == dev_enable0_oe)
		else $error("pin enables disagree");
	write_quiet_a: assert property (ocp_mcmd == sms_pkg::CMD_WR |=> ocp_sdata == 32'h0)
		else $error("read data on write");
	status_rsvd_a: assert property (rd && ocp_maddr == 8'h30 |=> ocp_sdata[31:2] == 30'h0)
		else $error("status reserved bits set");
	ctrl_rsvd_a: assert property (rd && ocp_maddr == 8'h2C |=> ocp_sdata[31:10] == 22'h0)
		else $error("control reserved bits set");
	// Main scenarios reached
	cv_err: cover property (ocp_sresp == 2'h3);
	cv_end: cover property ($rose(read_end));
	cv_mst: cover property ($rose(shift_clock_oe));
endmodule
bind sms_port sms_port_props props (.*);

// File: verif/sms_peer.sv
// Purpose: External 8-bit serial peripheral, enable active low, idle low
// Assumes: Phase 0: sample on rising clock, change on falling
// Notes:   Line shows inverse of last bit once released
`timescale 1ns/1ps
module sms_peer #(
	parameter logic [7:0] REPLY = 8'h5A
) (
	// Link
	input wire logic  sclk,
	input wire logic  sel_n,
	input wire logic  mosi,
	output logic      miso,
	output logic [7:0] got
);
	int idx = 7;
	initial miso = 1'b0;
	initial got = 8'h00;
	// Selection loads the top bit first
	always @(negedge sel_n)
	begin
		idx = 7;
		got = 8'h00;
		miso = REPLY[7];
	end
	// Capture on rising clock
	always @(posedge sclk) if (!sel_n) got = {got[6:0], mosi};
	// Next bit on falling clock
	always @(negedge sclk)
		if (!sel_n && idx > 0)
		begin
			idx--;
			miso = REPLY[idx];
		end
	// Released line must not hold a stale bit
	always @(posedge sel_n) miso = ~miso;
endmodule

// File: verif/sms_port_tb.sv
// Purpose: Self-checking bench of the serial port in master and slave mode
// Assumes: Default half period of four clocks
// Notes:   Slave select and external clock rest idle outside the slave scenario
`timescale 1ns/1ps
module sms_port_tb;
	logic clk = 0, srst = 1, dbg = 0, s_in;
	logic [2:0] mcmd = 0;
	logic [7:0] maddr = 0;
	logic [31:0] mdata = 0, sdata, q;
	logic [3:0] mbe = 0;
	logic [1:0] sresp, r;
	logic sck, sout, rend, sck_oe, sclk_m = 0, ssel = 1, mdo = 0;
	logic [4:0] en;
	logic [7:0] got;
	int fail_count = 0, tests_run = 0, i;
	always #10 clk = ~clk;
	sms_port uut (.clk(clk), .srst(srst), .ocp_mcmd(mcmd), .ocp_maddr(maddr),
		.ocp_mdata(mdata), .ocp_mbyteen(mbe), .ocp_dbg_access(dbg),
		.ocp_scmdaccept(), .ocp_sresp(sresp), .ocp_sdata(sdata),
		.shift_clock_i(sclk_m), .shift_clock_o(sck), .shift_clock_oe(sck_oe),
		.serial_in_pin(ssel ? s_in : mdo), .serial_out_pin(sout), .slave_select_in(ssel),
		.dev_enable_o(en), .dev_enable0_oe(), .read_end(rend));
	sms_peer peer (.sclk(sck), .sel_n(en[1]), .mosi(sout), .miso(s_in), .got(got));
	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// One command from a falling edge, answer taken a cycle later, then one idle cycle
	task automatic bus(input logic [2:0] c, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		mcmd = c;
		maddr = a;
		mdata = d;
		mbe = be;
		@(negedge clk);
		mcmd = 3'h0;
		r = sresp;
		q = sdata;
		@(negedge clk);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic reset_state;
		bus(3'h2, 8'h30, 0, 4'hF);
		chk("status", q, 32'h2);
		bus(3'h2, 8'h28, 0, 4'hF);
		chk("setup", q, 32'h0);
		bus(3'h2, 8'h3C, 0, 4'hF);
		chk("test", q, 32'h0);
		bus(3'h2, 8'h20, 0, 4'hF);
		chk("unmapped", r, 2'h3);
	endtask
	task automatic master_xfer;
		bus(3'h1, 8'h28, 32'h8000, 4'hF);
		chk("master oe", sck_oe, 1'b1);
		bus(3'h1, 8'h34, 32'hC3, 4'hF);
		bus(3'h2, 8'h30, 0, 4'hF);
		chk("tx empty", q[1], 1'b0);
		bus(3'h1, 8'h2C, 32'h9D, 4'hF);
		repeat (6) @(negedge clk);
		chk("en active", en, 5'h1D);
		bus(3'h1, 8'h28, 32'h0, 4'hF);
		chk("busy write", r, 2'h3);
		for (i = 0; i < 400 && rend !== 1'b1; i++) @(negedge clk);
		chk("done", rend, 1'b1);
		@(negedge clk);
		chk("sent", got, 8'hC3);
		bus(3'h2, 8'h28, 0, 4'hF);
		chk("setup kept", q, 32'h8000);
		bus(3'h2, 8'h2C, 0, 4'hF);
		chk("act clear", q, 32'h9C);
		dbg = 1;
		bus(3'h2, 8'h38, 0, 4'hF);
		dbg = 0;
		bus(3'h2, 8'h30, 0, 4'hF);
		chk("full dbg", q, 32'h3);
		bus(3'h2, 8'h38, 0, 4'hF);
		chk("rx", q[7:0], 8'h5A);
		bus(3'h2, 8'h30, 0, 4'hF);
		chk("popped", q[0], 1'b0);
	endtask
	task automatic lanes_pol;
		bus(3'h1, 8'h34, 32'h0, 4'h2);
		bus(3'h2, 8'h30, 0, 4'hF);
		chk("lane1", q[1], 1'b1);
		bus(3'h1, 8'h34, 32'h0, 4'h1);
		bus(3'h2, 8'h30, 0, 4'hF);
		chk("lane0", q[1], 1'b0);
		bus(3'h1, 8'h28, 32'h8080, 4'hF);
		repeat (3) @(negedge clk);
		chk("polarity", en, 5'h1B);
	endtask
	task automatic test_pins;
		bus(3'h1, 8'h3C, 32'h7, 4'hF);
		repeat (6) @(negedge clk);
		bus(3'h2, 8'h3C, 0, 4'hF);
		chk("test bits", q & 32'h7DF, 32'h6CF);
		// Forced low must loop back although the peer line rests high
		bus(3'h1, 8'h3C, 32'h3, 4'hF);
		bus(3'h2, 8'h3C, 0, 4'hF);
		chk("loop low", q[3], 1'b0);
		bus(3'h1, 8'h3C, 32'h0, 4'hF);
		bus(3'h2, 8'h3C, 0, 4'hF);
		chk("test off", q, 32'h0);
	endtask
	// Transmit only, clock idle high, phase 1 on device 1
	task automatic master_mode3;
		bus(3'h1, 8'h28, 32'h8802, 4'hF);
		repeat (3) @(negedge clk);
		chk("idle high", sck, 1'b1);
		bus(3'h1, 8'h34, 32'h96, 4'hF);
		bus(3'h1, 8'h2C, 32'h9E, 4'hF);
		for (i = 0; i < 100 && q[1] !== 1'b1; i++)
			bus(3'h2, 8'h30, 0, 4'hF);
		chk("tx done", q[1], 1'b1);
		chk("mode3 sent", got, 8'h96);
		chk("no read end", rend, 1'b0);
		bus(3'h2, 8'h2C, 0, 4'hF);
		chk("wr clear", q, 32'h9C);
	endtask
	// Bench acts as external master, 160 ns clock, phase 0
	task automatic slave_xfer;
		logic [7:0] rx_m = 8'h00;
		logic [7:0] pat  = 8'h3C;
		bus(3'h1, 8'h28, 32'h0, 4'hF);
		chk("slave oe", sck_oe, 1'b0);
		bus(3'h1, 8'h34, 32'hA5, 4'hF);
		bus(3'h1, 8'h2C, 32'h1D, 4'hF);
		ssel = 0;
		for (i = 7; i >= 0; i--)
		begin
			mdo = pat[i];
			repeat (4) @(negedge clk);
			sclk_m = 1;
			rx_m = {rx_m[6:0], sout};
			repeat (4) @(negedge clk);
			sclk_m = 0;
		end
		repeat (4) @(negedge clk);
		chk("sel held", rend, 1'b0);
		ssel = 1;
		for (i = 0; i < 20 && rend !== 1'b1; i++) @(negedge clk);
		chk("slave end", rend, 1'b1);
		chk("slave sent", rx_m, 8'hA5);
		bus(3'h2, 8'h38, 0, 4'hF);
		chk("slave got", q[7:0], 8'h3C);
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		srst = 0;
		@(negedge clk);
		reset_state();
		master_xfer();
		lanes_pol();
		test_pins();
		master_mode3();
		slave_xfer();
		results();
	end
endmodule
